// File: rtl/pefs_pkg.sv
package pefs_pkg;

    localparam int NUM_PINS       = 22;
    localparam int NUM_LOW_PINS   = 16;
    localparam int ADDR_W         = 4;
    localparam int DATA_W         = 16;

    // Register byte offsets, one halfword apart
    localparam logic [3:0] OFS_HIGH_SEL  = 4'h0;
    localparam logic [3:0] OFS_LOW_SEL_1 = 4'h2;
    localparam logic [3:0] OFS_LOW_SEL_2 = 4'h4;

    // Implemented width of the high register, bits above read as zero
    localparam int          HIGH_USED_W   = 12;
    localparam logic [11:0] HIGH_RESET    = 12'h000;
    localparam logic [15:0] LOW_RESET     = 16'h0000;
    localparam logic [15:0] RDATA_RESET   = 16'h0000;

    // Per-pin code values
    localparam logic [1:0] CODE_PORT      = 2'h0;
    localparam logic [1:0] CODE_PRIMARY   = 2'h1;
    localparam logic [1:0] CODE_SECOND    = 2'h2;
    localparam logic [1:0] CODE_THIRD     = 2'h3;

    // Pins with a secondary function
    localparam logic [4:0] PIN_SER3_RX    = 5'h04;
    localparam logic [4:0] PIN_SER3_TX    = 5'h05;
    localparam logic [4:0] PIN_SER3_CLK   = 5'h06;
    localparam logic [4:0] PIN_SER2_RX    = 5'h07;
    localparam logic [4:0] PIN_SER2_CLK   = 5'h08;
    localparam logic [4:0] PIN_SER2_TX    = 5'h0a;
    localparam logic [4:0] PIN_MAN_RESET  = 5'h0d;
    localparam logic [4:0] PIN_IRQ_OUT    = 5'h0f;
    localparam logic [4:0] PIN_BREAK_OUT  = 5'h10;

    typedef enum logic [2:0] {
        FN_PORT,
        FN_PRIMARY,
        FN_SECOND_OUT,
        FN_SECOND_IO,
        FN_SECOND_IN
    } pefs_func_t;

    // Signals driven by peripherals toward the pins
    typedef struct packed {
        logic        motor_w_neg_b_out;
        logic        motor_v_neg_b_out;
        logic        motor_u_neg_b_out;
        logic        motor_w_pos_a_out;
        logic        motor_v_pos_a_out;
        logic        motor_u_pos_a_out;
        logic [15:0] timer_line_out;
        logic        break_trigger_out;
        logic        interrupt_request_out;
        logic        serial2_transmit;
        logic        serial2_clock_out;
        logic        serial3_transmit;
        logic        serial3_clock_out;
    } pefs_periph_out_t;

    // Signals returned from the pins to peripherals
    typedef struct packed {
        logic [15:0] timer_line_in;
        logic        manual_reset_in;
        logic        serial2_receive;
        logic        serial2_clock_in;
        logic        serial3_receive;
        logic        serial3_clock_in;
    } pefs_periph_in_t;

endpackage : pefs_pkg

// File: rtl/pefs_port_e_pin_function_select.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// [R1] Three 16-bit read/write function select registers
// [R2] Two-bit code per pin; 00 is port
// [R3] High register bits 15:12 read zero
// [R4] High register bits 11:0 hold pins 21-16
// [R5] Pins 21-17: 01 motor output, else prohibited
// [R6] Pin 16: 01 motor U, 10 break trigger
// [R7] Mask ROM software never selects break trigger
// [R8] Pin 15: 01 timer 4D, 11 interrupt out
// [R9] Timer-only pins allow just 00 and 01
// [R10] Pin 13: 01 timer 4B, 10 manual reset
// [R11] Pin 10: 01 timer 3C, 10 serial2 transmit
// [R12] Pin 8: 01 timer 3A, 10 serial2 clock
// [R13] Pin 7: 01 timer 2B, 10 serial2 receive
// [R14] Pin 6: 01 timer 2A, 10 serial3 clock
// [R15] Pin 5: 01 timer 1B, 10 serial3 transmit
// [R16] Pin 4: 01 timer 1A, 10 serial3 receive
// [R17] Port, timer, serial clock use direction bit
// [R18] All codes zero after reset
// [R19] Prohibited codes fall back to port
module pefs_port_e_pin_function_select (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [3:0]                addr,
    input  wire logic [15:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic [15:0]                    rdata,
    input  wire logic [21:0]               port_dir,
    input  wire logic [21:0]               port_out_data,
    output logic [21:0]                    port_pin_level,
    input  wire pefs_pkg::pefs_periph_out_t periph_out,
    output pefs_pkg::pefs_periph_in_t      periph_in,
    input  wire logic [21:0]               pad_in,
    output logic [21:0]                    pad_out,
    output logic [21:0]                    pad_oe
);
    import pefs_pkg::*;

    logic [11:0]      high_sel_reg;
    logic [15:0]      low_sel_1_reg;
    logic [15:0]      low_sel_2_reg;
    logic [15:0]      rdata_reg;
    logic [21:0]      sync1_reg;
    logic [21:0]      sync2_reg;
    logic [21:0]      pad_out_next;
    logic [21:0]      pad_oe_next;
    logic [21:0]      pad_out_reg;
    logic [21:0]      pad_oe_reg;
    pefs_periph_in_t  periph_in_next;
    pefs_periph_in_t  periph_in_reg;
    logic [21:0]      primary_out;
    logic [21:0]      second_out;
    logic [43:0]      all_codes;

    // Decode one pin's code into the kind of connection it asks for
    function automatic pefs_func_t pin_func(input logic [4:0] pin, input logic [1:0] code);
        pefs_func_t f;
        f = FN_PORT;                                            // [R19]
        if (code == CODE_PRIMARY) begin
            f = FN_PRIMARY;                                     // [R5] [R9]
        end else if (code == CODE_SECOND) begin
            unique case (pin)
                PIN_BREAK_OUT: f = FN_SECOND_OUT;               // [R6]
                PIN_MAN_RESET: f = FN_SECOND_IN;                // [R10]
                PIN_SER2_TX:   f = FN_SECOND_OUT;               // [R11]
                PIN_SER2_CLK:  f = FN_SECOND_IO;                // [R12]
                PIN_SER2_RX:   f = FN_SECOND_IN;                // [R13]
                PIN_SER3_CLK:  f = FN_SECOND_IO;                // [R14]
                PIN_SER3_TX:   f = FN_SECOND_OUT;               // [R15]
                PIN_SER3_RX:   f = FN_SECOND_IN;                // [R16]
                default:       f = FN_PORT;                     // [R19]
            endcase
        end else if (code == CODE_THIRD && pin == PIN_IRQ_OUT) begin
            f = FN_SECOND_OUT;                                  // [R8]
        end
        return f;
    endfunction : pin_func

    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high_sel_reg  <= HIGH_RESET;                        // [R18]
            low_sel_1_reg <= LOW_RESET;
            low_sel_2_reg <= LOW_RESET;
        end else if (wr) begin
            unique case (addr)
                OFS_HIGH_SEL:  high_sel_reg  <= wdata[HIGH_USED_W-1:0]; // [R1] [R3]
                OFS_LOW_SEL_1: low_sel_1_reg <= wdata;          // [R1]
                OFS_LOW_SEL_2: low_sel_2_reg <= wdata;
                default: ;
            endcase
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RDATA_RESET;
        end else if (rd) begin
            unique case (addr)
                OFS_HIGH_SEL:  rdata_reg <= {4'h0, high_sel_reg};   // [R3]
                OFS_LOW_SEL_1: rdata_reg <= low_sel_1_reg;
                OFS_LOW_SEL_2: rdata_reg <= low_sel_2_reg;
                default:       rdata_reg <= RDATA_RESET;
            endcase
        end else begin
            rdata_reg <= RDATA_RESET;
        end
    end

    // Pad inputs are asynchronous to clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 22'h000000;
            sync2_reg <= 22'h000000;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Pin k uses bits 2k+1:2k counted across high, low 1, low 2
    assign all_codes = {high_sel_reg, low_sel_1_reg, low_sel_2_reg}; // [R2] [R4]

    // Code 01 on pins 21-16 is a motor phase, below that a timer line
    assign primary_out = {periph_out.motor_w_neg_b_out, periph_out.motor_v_neg_b_out,
                          periph_out.motor_u_neg_b_out, periph_out.motor_w_pos_a_out,
                          periph_out.motor_v_pos_a_out, periph_out.motor_u_pos_a_out,
                          periph_out.timer_line_out};          // [R5] [R6]

    always_comb begin
        second_out                = 22'h000000;
        second_out[PIN_BREAK_OUT] = periph_out.break_trigger_out;
        second_out[PIN_IRQ_OUT]   = periph_out.interrupt_request_out;
        second_out[PIN_SER2_TX]   = periph_out.serial2_transmit;
        second_out[PIN_SER2_CLK]  = periph_out.serial2_clock_out;
        second_out[PIN_SER3_CLK]  = periph_out.serial3_clock_out;
        second_out[PIN_SER3_TX]   = periph_out.serial3_transmit;
    end

    always_comb begin
        pefs_func_t f;
        f = FN_PORT;
        pad_out_next   = 22'h000000;
        pad_oe_next    = 22'h000000;
        periph_in_next = '0;
        // Idle levels so a deselected receiver sees no activity
        periph_in_next.manual_reset_in = 1'b1;
        periph_in_next.serial2_receive = 1'b1;
        periph_in_next.serial3_receive = 1'b1;
        for (int i = 0; i < NUM_PINS; i++) begin
            f = pin_func(5'(i), all_codes[2*i +: 2]);
            unique case (f)
                FN_PORT: begin
                    pad_out_next[i] = port_out_data[i];
                    pad_oe_next[i]  = port_dir[i];              // [R17]
                end
                FN_PRIMARY: begin
                    pad_out_next[i] = primary_out[i];
                    // Motor phases are pure outputs
                    pad_oe_next[i]  = (i < NUM_LOW_PINS) ? port_dir[i] : 1'b1; // [R17]
                end
                FN_SECOND_OUT: begin
                    pad_out_next[i] = second_out[i];
                    pad_oe_next[i]  = 1'b1;
                end
                FN_SECOND_IO: begin
                    pad_out_next[i] = second_out[i];
                    pad_oe_next[i]  = port_dir[i];              // [R17]
                end
                FN_SECOND_IN: begin
                    pad_oe_next[i]  = 1'b0;
                end
            endcase
        end
        for (int i = 0; i < NUM_LOW_PINS; i++) begin
            if (pin_func(5'(i), all_codes[2*i +: 2]) == FN_PRIMARY) begin
                periph_in_next.timer_line_in[i] = sync2_reg[i]; // [R9]
            end
        end
        if (pin_func(PIN_MAN_RESET, all_codes[2*PIN_MAN_RESET +: 2]) == FN_SECOND_IN) begin
            periph_in_next.manual_reset_in = sync2_reg[PIN_MAN_RESET]; // [R10]
        end
        if (pin_func(PIN_SER2_RX, all_codes[2*PIN_SER2_RX +: 2]) == FN_SECOND_IN) begin
            periph_in_next.serial2_receive = sync2_reg[PIN_SER2_RX]; // [R13]
        end
        if (pin_func(PIN_SER3_RX, all_codes[2*PIN_SER3_RX +: 2]) == FN_SECOND_IN) begin
            periph_in_next.serial3_receive = sync2_reg[PIN_SER3_RX]; // [R16]
        end
        if (pin_func(PIN_SER2_CLK, all_codes[2*PIN_SER2_CLK +: 2]) == FN_SECOND_IO) begin
            periph_in_next.serial2_clock_in = sync2_reg[PIN_SER2_CLK]; // [R12]
        end
        if (pin_func(PIN_SER3_CLK, all_codes[2*PIN_SER3_CLK +: 2]) == FN_SECOND_IO) begin
            periph_in_next.serial3_clock_in = sync2_reg[PIN_SER3_CLK]; // [R14]
        end
    end

    // Registered pad and peripheral sides; safe port state out of reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_out_reg   <= 22'h000000;
            pad_oe_reg    <= 22'h000000;
            periph_in_reg <= '{timer_line_in: 16'h0000, manual_reset_in: 1'b1,
                               serial2_receive: 1'b1, serial2_clock_in: 1'b0,
                               serial3_receive: 1'b1, serial3_clock_in: 1'b0};
        end else begin
            pad_out_reg   <= pad_out_next;
            pad_oe_reg    <= pad_oe_next;
            periph_in_reg <= periph_in_next;
        end
    end

    // Port logic always sees the pin level, whatever the function
    assign port_pin_level = sync2_reg;
    assign pad_out        = pad_out_reg;
    assign pad_oe         = pad_oe_reg;
    assign periph_in      = periph_in_reg;
    assign rdata          = rdata_reg;

endmodule : pefs_port_e_pin_function_select

// File: test/pefs_sva_asserts.sv
`timescale 1ns/1ps
module pefs_sva
    import pefs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [3:0]       addr,
    input  wire logic [15:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    input  wire logic [15:0]      rdata,
    input  wire logic [21:0]      port_dir,
    input  wire logic [21:0]      port_out_data,
    input  wire pefs_periph_out_t periph_out,
    input  wire pefs_periph_in_t  periph_in,
    input  wire logic [21:0]      pad_in,
    input  wire logic [21:0]      pad_out,
    input  wire logic [21:0]      pad_oe
);
    // Shadow of the codes, pin k at bits 2k+1:2k
    logic [47:0] sh_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sh_reg <= '0;
        else if (wr && addr == 4'h0) sh_reg[47:32] <= {4'h0, wdata[11:0]};
        else if (wr && addr == 4'h2) sh_reg[31:16] <= wdata;
        else if (wr && addr == 4'h4) sh_reg[15:0] <= wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_low1;
        wr && addr == 4'h2;
    endsequence
    sequence s_rd_low1;
        rd && !wr && addr == 4'h2;
    endsequence
    AST_WR_RD: assert property (s_wr_low1 ##1 s_rd_low1 |=> rdata == $past(wdata, 2))
        else $error("read back differs from write");
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_HI_RSVD: assert property (rd && addr == 4'h0 |=> rdata[15:12] == 4'h0)
        else $error("reserved high bits read nonzero");
    AST_PORT0: assert property (!$past(rst) && $past(sh_reg[1:0]) == 2'h0 |->
        pad_oe[0] == $past(port_dir[0]) && pad_out[0] == $past(port_out_data[0]))
        else $error("port mode pin 0 wrong");
    AST_MOTOR21: assert property (!$past(rst) && $past(sh_reg[43:42]) == 2'h1 |->
        pad_oe[21] && pad_out[21] == $past(periph_out.motor_w_neg_b_out))
        else $error("pin 21 motor output wrong");
    AST_IRQ15: assert property (!$past(rst) && $past(sh_reg[31:30]) == 2'h3 |->
        pad_oe[15] && pad_out[15] == $past(periph_out.interrupt_request_out))
        else $error("pin 15 interrupt output wrong");
    AST_PROHIB14: assert property (!$past(rst) && $past(sh_reg[29:28]) == 2'h3 |->
        pad_oe[14] == $past(port_dir[14]) && pad_out[14] == $past(port_out_data[14]))
        else $error("prohibited code not port");
    AST_RX7: assert property ($past(sh_reg[15:14], 3) == 2'h2 &&
        $past(sh_reg[15:14]) == 2'h2
        |-> !pad_oe[7] && periph_in.serial2_receive == $past(pad_in[7], 3))
        else $error("serial2 receive path wrong");
    AST_MRES13: assert property (!$past(rst) && $past(sh_reg[27:26]) != 2'h2 |->
        periph_in.manual_reset_in)
        else $error("manual reset not idle");
endmodule : pefs_sva

bind pefs_port_e_pin_function_select pefs_sva u_sva (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_dir(port_dir),
    .port_out_data(port_out_data), .periph_out(periph_out), .periph_in(periph_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// File: test/pefs_periph_model.sv
`timescale 1ns/1ps
module pefs_periph_model
    import pefs_pkg::*;
(
    input  wire logic     level,
    output pefs_periph_out_t periph_out
);
    // One level on every source, so any selected path shows against port data 0
    assign periph_out = pefs_periph_out_t'({$bits(pefs_periph_out_t){level}});
endmodule : pefs_periph_model

// File: test/tb_port_e_pin_function_select.sv
`timescale 1ns/1ps
module tb_port_e_pin_function_select;
    import pefs_pkg::*;
    logic             clk, rst, wr, rd, level;
    logic [3:0]       addr;
    logic [15:0]      wdata, rdata;
    logic [21:0]      port_dir, port_out_data, port_pin_level, pad_in, pad_out, pad_oe;
    pefs_periph_out_t periph_out;
    pefs_periph_in_t  periph_in;
    int               n_mismatch = 0, samples_checked = 0, cyc = 0;

    pefs_port_e_pin_function_select u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .port_dir(port_dir), .port_out_data(port_out_data),
        .port_pin_level(port_pin_level), .periph_out(periph_out), .periph_in(periph_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    pefs_periph_model u_periph (.level(level), .periph_out(periph_out));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // One idle edge so a following write never reassigns wr in the same step
        @(posedge clk);
    endtask : wr_reg

    // Read slot is one cycle only, so sample just after the taking edge
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string msg);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, msg);
        @(posedge clk);
    endtask : rd_chk

    task automatic mux_row(input logic [4:0] pin, input logic [1:0] code, input logic oe,
                           input logic out);
        logic [3:0]  a;
        a = (pin >= 5'h10) ? 4'h0 : (pin >= 5'h08) ? 4'h2 : 4'h4;
        wr_reg(a, 16'(code) << (2 * pin[2:0]));
        @(posedge clk);
        #1;
        check(16'(pad_oe[pin]), 16'(oe), "pin enable");
        if (oe) check(16'(pad_out[pin]), 16'(out), "pin drive");
        @(posedge clk);
        wr_reg(a, 16'h0000);
    endtask : mux_row

    task automatic t_reset();
        rd_chk(4'h0, 16'h0000, "high reset");
        rd_chk(4'h2, 16'h0000, "low1 reset");
        rd_chk(4'h4, 16'h0000, "low2 reset");
        #1;
        check(pad_oe[15:0], 16'hffff, "port enables");
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr_reg(4'h0, 16'hffff);
        rd_chk(4'h0, 16'h0fff, "high reserved");
        wr_reg(4'h4, 16'h3c5a);
        // Write straight into read, no gap, as the master may do
        addr <= 4'h2;
        wdata <= 16'ha5c3;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd_chk(4'h2, 16'ha5c3, "low1 back");
        rd_chk(4'h4, 16'h3c5a, "low2 back");
        wr_reg(4'h6, 16'hffff);
        rd_chk(4'h6, 16'h0000, "unmapped");
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h4, 16'h0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_mux();
        mux_row(5'h15, 2'h1, 1'b1, 1'b1);
        mux_row(5'h13, 2'h1, 1'b1, 1'b1);
        mux_row(5'h11, 2'h2, 1'b1, 1'b0);
        mux_row(5'h10, 2'h1, 1'b1, 1'b1);
        // Bench plays a flash part; mask ROM software never picks this
        mux_row(5'h10, 2'h2, 1'b1, 1'b1);
        mux_row(5'h10, 2'h3, 1'b1, 1'b0);
        mux_row(5'h0f, 2'h1, 1'b1, 1'b1);
        mux_row(5'h0f, 2'h2, 1'b1, 1'b0);
        mux_row(5'h0f, 2'h3, 1'b1, 1'b1);
        mux_row(5'h0e, 2'h3, 1'b1, 1'b0);
        mux_row(5'h00, 2'h1, 1'b1, 1'b1);
        mux_row(5'h0d, 2'h2, 1'b0, 1'b0);
        mux_row(5'h0a, 2'h2, 1'b1, 1'b1);
        mux_row(5'h08, 2'h2, 1'b1, 1'b1);
        mux_row(5'h07, 2'h2, 1'b0, 1'b0);
        mux_row(5'h06, 2'h2, 1'b1, 1'b1);
        mux_row(5'h05, 2'h2, 1'b1, 1'b1);
        mux_row(5'h04, 2'h2, 1'b0, 1'b0);
        port_dir <= 22'h000000;
        mux_row(5'h0c, 2'h1, 1'b0, 1'b0);
        port_dir <= 22'h3fffff;
        $display("test mux done");
    endtask : t_mux

    task automatic t_inputs();
        wr_reg(4'h2, 16'h0800);
        wr_reg(4'h4, 16'h8000);
        pad_in <= 22'h3fdf7f;
        repeat (4) @(posedge clk);
        #1;
        check(16'(periph_in.serial2_receive), 16'h0000, "rx2 low");
        check(16'(periph_in.manual_reset_in), 16'h0000, "manual_reset_in low");
        check(port_pin_level[15:0], 16'hdf7f, "pin level");
        @(posedge clk);
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h4, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        check(16'(periph_in.serial2_receive), 16'h0001, "rx2 idle");
        check(16'(periph_in.manual_reset_in), 16'h0001, "manual_reset_in idle");
        @(posedge clk);
        pad_in <= 22'h3fffff;
        $display("test inputs done");
    endtask : t_inputs

    task automatic t_rerst();
        wr_reg(4'h2, 16'h5555);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(4'h2, 16'h0000, "mid reset");
        $display("test rerst done");
    endtask : t_rerst

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        level = 1'b1;
        port_dir = 22'h3fffff;
        port_out_data = 22'h000000;
        pad_in = 22'h3fffff;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_regs();
        t_mux();
        t_inputs();
        t_rerst();
        tally_and_finish();
    end
endmodule : tb_port_e_pin_function_select
